//--- rtl/csc_cfg.svh
`ifndef CSC_CFG_SVH
`define CSC_CFG_SVH
// Register byte addresses (index times four)
`define CSC_SLEW_IDX        16'h1c16
`define CSC_ADDR_SLEW       16'h7058
`define CSC_ADDR_SRCSEL     16'h7060
`define CSC_ADDR_STATUS3    16'h7064
`define CSC_ADDR_BOOTCFG    16'h7068
`define CSC_ADDR_PLLCFG     16'h706c
// Field positions and widths
`define CSC_SRC_W           2
`define CSC_OFF_BIT         0
`define CSC_SLEW_W          16
// Reset values
`define CSC_SLEW_RST        16'h0000
`define CSC_SRC_RST         2'h0
`define CSC_PLL_MULT_RST    8'h01
// Boot reference choices, serial targets, PLL ceiling and RTC rate in kHz
`define CSC_REF0_KHZ        32'd11290
`define CSC_REF1_KHZ        32'd12000
`define CSC_REF2_KHZ        32'd12288
`define CSC_SPI_KHZ         32'd500
`define CSC_I2C_KHZ         32'd400
`define CSC_PLL_MAX_KHZ     32'd120000
`define CSC_RTC_KHZ         32'd32
// Disable handover: cycles the pin keeps low before release
`define CSC_PARK_CYC        2'h2
`endif

//--- rtl/csc_pkg.sv
package csc_pkg;
    // Handover states of the debug clock output pin
    typedef enum logic [1:0] {
        CSC_DRIVE,
        CSC_PARK,
        CSC_HIZ
    } csc_pin_state_t;
    // Source choices for the debug clock output
    typedef enum logic [1:0] {
        CSC_SRC_SYS,
        CSC_SRC_REF,
        CSC_SRC_RTC,
        CSC_SRC_DIV
    } csc_src_t;
endpackage : csc_pkg

//--- rtl/csc_divider.sv
`timescale 1ns/100ps
`include "csc_cfg.svh"
// Programmable divider producing a one-cycle enable pulse
module csc_divider (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // Control
    input  wire logic [15:0] div_value,
    // Output pulse
    output logic             tick
);
    logic [15:0] count_reg; // Cycles since last pulse

    // Count up to the divisor and emit one pulse each wrap
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count_reg <= 16'h0000;
            tick      <= 1'b0;
        end else if (count_reg >= div_value) begin
            count_reg <= 16'h0000;
            tick      <= 1'b1;
        end else begin
            count_reg <= count_reg + 16'h0001;
            tick      <= 1'b0;
        end
    end
endmodule : csc_divider

//--- rtl/csc_clock_select.sv
`timescale 1ns/100ps
`include "csc_cfg.svh"
module csc_clock_select (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // Avalon-MM slave
    input  wire logic [15:0] avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // Board inputs, sampled on clk
    input  wire logic        clock_select,
    input  wire logic        external_reference_input,
    input  wire logic        rtc_osc_input,
    input  wire logic        pll_clock_input,
    // Clock routing outputs
    output logic             sysgen_reference,
    output logic             rtc_timer_clock,
    output logic             pll_bypass,
    // Debug clock output pin
    output logic             debug_clock_output_o,
    output logic             debug_clock_output_oe,
    output logic [15:0]      output_slew_level,
    // Serial clock enables from boot settings
    output logic             spi_clock_tick,
    output logic             i2c_clock_tick
);
    logic [15:0]          output_slew_register_reg;        // Slew control
    logic [1:0]           output_source_field_reg;         // Pin source
    logic                 output_disable_bit_reg;          // Status bit
    logic [1:0]           boot_ref_reg;                    // Assumed reference
    logic                 bypass_reg;                      // PLL bypass flag
    logic [7:0]           pll_mult_reg;                    // PLL multiplier
    logic                 pll_over_reg;                    // Refused setting seen
    logic                 select_reg;                      // Sampled strap
    logic                 access_reg;                      // Bus answer phase
    logic [1:0]           park_cnt_reg;                    // Handover count
    csc_pkg::csc_pin_state_t pin_state_reg;                // Pin handover state
    logic                 gen_clk_div;                     // Slow source tap
    logic                 spi_tick;                        // Divider pulse
    logic                 i2c_tick;                        // Divider pulse
    logic                 src_clock;                       // Selected source
    logic [31:0]          ref_khz;                         // Assumed reference
    logic [15:0]          spi_div;                         // SPI divisor
    logic [15:0]          i2c_div;                         // I2C divisor

    // Reference in kHz for a boot choice
    function automatic logic [31:0] ref_of(input logic [1:0] sel);
        case (sel)
            2'h1:    ref_of = `CSC_REF1_KHZ;
            2'h2:    ref_of = `CSC_REF2_KHZ;
            default: ref_of = `CSC_REF0_KHZ;
        endcase
    endfunction : ref_of

    // Divisor giving a target rate from a reference, as cycles minus one
    function automatic logic [15:0] div_of(input logic [31:0] ref_k, input logic [31:0] tgt_k);
        logic [31:0] q;
        q = (ref_k + tgt_k - 32'd1) / tgt_k;
        div_of = q[15:0] - 16'h0001;
    endfunction : div_of

    assign ref_khz = ref_of(boot_ref_reg);
    assign spi_div = div_of(ref_khz, `CSC_SPI_KHZ);
    assign i2c_div = div_of(ref_khz, `CSC_I2C_KHZ);

    // Strap resampled every cycle; the board must keep it still
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            select_reg <= 1'b0;
        end else begin
            select_reg <= clock_select;
        end
    end

    // Reference routing: oscillator always on RTC timer
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sysgen_reference <= 1'b0;
            rtc_timer_clock  <= 1'b0;
        end else begin
            rtc_timer_clock <= rtc_osc_input;
            if (select_reg) begin
                sysgen_reference <= external_reference_input;
            end else begin
                sysgen_reference <= rtc_osc_input;
            end
        end
    end

    // Source multiplexer for the debug pin
    always_comb begin
        case (csc_pkg::csc_src_t'(output_source_field_reg))
            csc_pkg::CSC_SRC_SYS: src_clock = pll_bypass ? sysgen_reference : pll_clock_input;
            csc_pkg::CSC_SRC_REF: src_clock = sysgen_reference;
            csc_pkg::CSC_SRC_RTC: src_clock = rtc_timer_clock;
            csc_pkg::CSC_SRC_DIV: src_clock = gen_clk_div;
            default:              src_clock = 1'b0;
        endcase
    end

    // Divided tap toggles on each SPI tick
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            gen_clk_div <= 1'b0;
        end else if (spi_tick) begin
            gen_clk_div <= ~gen_clk_div;
        end
    end

    // Pin handover: hold low a few cycles before releasing, avoiding a runt pulse
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_state_reg         <= csc_pkg::CSC_DRIVE;
            park_cnt_reg          <= 2'h0;
            debug_clock_output_o  <= 1'b0;
            debug_clock_output_oe <= 1'b1;
        end else begin
            case (pin_state_reg)
                csc_pkg::CSC_DRIVE: begin
                    debug_clock_output_o  <= src_clock;
                    debug_clock_output_oe <= 1'b1;
                    if (output_disable_bit_reg) begin
                        pin_state_reg        <= csc_pkg::CSC_PARK;
                        park_cnt_reg         <= 2'h0;
                        debug_clock_output_o <= 1'b0;
                    end
                end
                csc_pkg::CSC_PARK: begin
                    debug_clock_output_o <= 1'b0;
                    if (!output_disable_bit_reg) begin
                        pin_state_reg <= csc_pkg::CSC_DRIVE;
                    end else if (park_cnt_reg == `CSC_PARK_CYC - 2'h1) begin
                        pin_state_reg         <= csc_pkg::CSC_HIZ;
                        debug_clock_output_oe <= 1'b0;
                    end else begin
                        park_cnt_reg <= park_cnt_reg + 2'h1;
                    end
                end
                csc_pkg::CSC_HIZ: begin
                    debug_clock_output_o  <= 1'b0;
                    debug_clock_output_oe <= 1'b0;
                    if (!output_disable_bit_reg) begin
                        pin_state_reg <= csc_pkg::CSC_DRIVE;
                    end
                end
                default: begin
                    pin_state_reg <= csc_pkg::CSC_DRIVE;
                end
            endcase
        end
    end

    // Register writes; bus answers on the second cycle of each access
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            output_slew_register_reg <= `CSC_SLEW_RST;
            output_source_field_reg  <= `CSC_SRC_RST;
            output_disable_bit_reg   <= 1'b0;
            boot_ref_reg             <= 2'h0;
            bypass_reg               <= 1'b1;
            pll_mult_reg             <= `CSC_PLL_MULT_RST;
            pll_over_reg             <= 1'b0;
        end else if (avs_write && access_reg) begin
            case (avs_address)
                `CSC_ADDR_SLEW:    output_slew_register_reg <= avs_writedata[15:0];
                `CSC_ADDR_SRCSEL:  output_source_field_reg  <= avs_writedata[1:0];
                `CSC_ADDR_STATUS3: output_disable_bit_reg   <= avs_writedata[`CSC_OFF_BIT];
                `CSC_ADDR_BOOTCFG: begin
                    boot_ref_reg <= (avs_writedata[1:0] == 2'h3) ? 2'h0 : avs_writedata[1:0];
                    bypass_reg   <= avs_writedata[4];
                end
                `CSC_ADDR_PLLCFG: begin
                    // Refuse multipliers that push the output past the ceiling
                    if (ref_khz * {24'h000000, avs_writedata[7:0]} > `CSC_PLL_MAX_KHZ) begin
                        pll_over_reg <= 1'b1;
                    end else begin
                        pll_mult_reg <= avs_writedata[7:0];
                        pll_over_reg <= 1'b0;
                    end
                end
                default: ;
            endcase
        end
    end

    assign pll_bypass = bypass_reg;

    // Slew level follows the register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            output_slew_level <= `CSC_SLEW_RST;
        end else begin
            output_slew_level <= output_slew_register_reg;
        end
    end

    // Bus handshake and read data
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            access_reg      <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h00000000;
        end else begin
            access_reg      <= (avs_read || avs_write) && !access_reg;
            avs_waitrequest <= !((avs_read || avs_write) && !access_reg);
            if (avs_read && !access_reg) begin
                case (avs_address)
                    `CSC_ADDR_SLEW:    avs_readdata <= {16'h0000, output_slew_register_reg};
                    `CSC_ADDR_SRCSEL:  avs_readdata <= {30'h0, output_source_field_reg};
                    `CSC_ADDR_STATUS3: avs_readdata <= {28'h0000000, pin_state_reg == csc_pkg::CSC_HIZ,
                                                        select_reg, 1'b0, output_disable_bit_reg};
                    `CSC_ADDR_BOOTCFG: avs_readdata <= {27'h0, bypass_reg, 2'h0, boot_ref_reg};
                    `CSC_ADDR_PLLCFG:  avs_readdata <= {23'h0, pll_over_reg, pll_mult_reg};
                    default:           avs_readdata <= 32'h00000000;
                endcase
            end
        end
    end

    // Serial clock dividers from the assumed boot reference
    csc_divider u_spi_div (
        .clk       (clk),
        .reset_n   (reset_n),
        .div_value (spi_div),
        .tick      (spi_tick)
    );
    csc_divider u_i2c_div (
        .clk       (clk),
        .reset_n   (reset_n),
        .div_value (i2c_div),
        .tick      (i2c_tick)
    );

    // Registered copies of the serial ticks
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            spi_clock_tick <= 1'b0;
            i2c_clock_tick <= 1'b0;
        end else begin
            spi_clock_tick <= spi_tick;
            i2c_clock_tick <= i2c_tick;
        end
    end
endmodule : csc_clock_select

//--- verif/csc_clock_select_sva.sv
`timescale 1ns/100ps
`include "csc_cfg.svh"
// Bus answer, pin handover and clock routing seen at the top ports
module csc_clock_select_sva (
    // Clock and reset
    input wire logic        clk,
    input wire logic        reset_n,
    // Register bus
    input wire logic [15:0] avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic        avs_waitrequest,
    // Board inputs and routing
    input wire logic        clock_select,
    input wire logic        external_reference_input,
    input wire logic        rtc_osc_input,
    input wire logic        sysgen_reference,
    input wire logic        pll_bypass,
    // Debug clock output pin
    input wire logic        debug_clock_output_o,
    input wire logic        debug_clock_output_oe,
    input wire logic [15:0] output_slew_level
);
    logic [2:0] up_cnt;   // Cycles since reset, saturating
    // Routing outputs still hold reset values for a few cycles
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            up_cnt <= 3'h0;
        end else if (up_cnt != 3'h7) begin
            up_cnt <= up_cnt + 3'h1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Accepted write to one register
    sequence s_wr(a);
        avs_write && !avs_waitrequest && avs_address == a;
    endsequence
    sequence s_off;
        s_wr(`CSC_ADDR_STATUS3) ##0 avs_writedata[`CSC_OFF_BIT];
    endsequence
    sequence s_on;
        s_wr(`CSC_ADDR_STATUS3) ##0 !avs_writedata[`CSC_OFF_BIT];
    endsequence
    property p_answer; $rose(avs_read || avs_write) |=> !avs_waitrequest; endproperty
    a_answer: assert property (p_answer) else $error("late bus answer");
    property p_one; !avs_waitrequest |=> avs_waitrequest; endproperty
    a_one: assert property (p_one) else $error("answer held too long");
    property p_oe_rst; $rose(reset_n) |-> debug_clock_output_oe; endproperty
    a_oe_rst: assert property (p_oe_rst) else $error("pin not driven after reset");
    property p_off; s_off |-> ##[1:4] !debug_clock_output_oe; endproperty
    a_off: assert property (p_off) else $error("pin still driven");
    property p_park; $fell(debug_clock_output_oe) |-> !$past(debug_clock_output_o); endproperty
    a_park: assert property (p_park) else $error("pin released while high");
    property p_on; s_on |-> ##[1:3] debug_clock_output_oe; endproperty
    a_on: assert property (p_on) else $error("pin not driven again");
    // Slew level is a registered copy of the register, so it follows one edge after the write lands
    property p_slew; s_wr(`CSC_ADDR_SLEW) |-> ##2 output_slew_level == $past(avs_writedata[15:0], 2); endproperty
    a_slew: assert property (p_slew) else $error("slew level not updated");
    property p_byp; s_wr(`CSC_ADDR_BOOTCFG) |=> pll_bypass == $past(avs_writedata[4]); endproperty
    a_byp: assert property (p_byp) else $error("bypass level wrong");
    property p_ext;
        (up_cnt == 3'h7 && clock_select && $stable(external_reference_input)) [*3]
            |-> sysgen_reference == external_reference_input;
    endproperty
    a_ext: assert property (p_ext) else $error("generator not on external input");
    property p_osc;
        (up_cnt == 3'h7 && !clock_select && $stable(rtc_osc_input)) [*3] |-> sysgen_reference == rtc_osc_input;
    endproperty
    a_osc: assert property (p_osc) else $error("generator not on oscillator");
endmodule : csc_clock_select_sva
bind csc_clock_select csc_clock_select_sva csc_clock_select_sva_inst (.*);

//--- verif/csc_board_model.sv
`timescale 1ns/100ps
// Board strap and external reference source
module csc_board_model (
    // Clock and strap level
    input  wire logic clk,
    input  wire logic strap_in,
    // Board pins
    output logic      clock_select,
    output logic      external_reference_input,
    output logic      rtc_osc_input,
    output logic      pll_clock_input
);
    int cnt = 0;  // Cycle count for the slow board clocks
    // Plain strap level; the bench moves it only inside reset
    assign clock_select = strap_in;
    initial begin
        external_reference_input = 1'b0;
        rtc_osc_input = 1'b0;
        pll_clock_input = 1'b0;
    end
    // External source runs only when selected, else tied to ground
    always @(posedge clk) begin
        cnt <= cnt + 1;
        external_reference_input <= strap_in && ((cnt / 5) % 2 == 1);
        rtc_osc_input <= ((cnt / 7) % 2 == 1);
        pll_clock_input <= ~pll_clock_input;
    end
endmodule : csc_board_model

//--- verif/tb.sv
`timescale 1ns/100ps
`include "csc_cfg.svh"
module tb;
    logic        clk = 1'b0, reset_n = 1'b0, strap = 1'b0;  // Clock, reset, strap request
    logic [15:0] avs_address = 16'h0000, slew;              // Bus address, slew output
    logic        avs_read = 1'b0, avs_write = 1'b0;         // Bus strobes
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q;    // Bus data, last read
    logic        wreq, sel, ext_in, rtc_in, pll_in, sysr, rtcc, byp, pin_o, pin_oe, spi_t, i2c_t;
    int          n_mismatch = 0, num_checks = 0, cyc = 0, r, g, k;
    int          refk[3] = '{`CSC_REF0_KHZ, `CSC_REF1_KHZ, `CSC_REF2_KHZ};  // Boot references in kHz
    logic        rtc_d1 = 1'b0, rtc_d2 = 1'b0, ext_d1 = 1'b0;  // Board levels one and two edges back
    always #50 clk = ~clk;
    // Bench model of the routing flops: each routed clock lags its board pin by one edge, the pin by two
    always @(posedge clk) begin
        rtc_d1 <= rtc_in;
        rtc_d2 <= rtc_d1;
        ext_d1 <= ext_in;
    end
    csc_board_model csc_board_model_inst (.clk(clk), .strap_in(strap), .clock_select(sel),
        .external_reference_input(ext_in), .rtc_osc_input(rtc_in), .pll_clock_input(pll_in));
    csc_clock_select csc_clock_select_inst (.clk(clk), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(wreq), .clock_select(sel),
        .external_reference_input(ext_in), .rtc_osc_input(rtc_in), .pll_clock_input(pll_in),
        .sysgen_reference(sysr), .rtc_timer_clock(rtcc), .pll_bypass(byp), .debug_clock_output_o(pin_o),
        .debug_clock_output_oe(pin_oe), .output_slew_level(slew), .spi_clock_tick(spi_t), .i2c_clock_tick(i2c_t));
    task automatic finish_test;
        $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test
    // Hang guard: the whole run needs under a thousand cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc > 20000) begin
            n_mismatch++;
            finish_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // One bus cycle; request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge clk); while (wreq !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask : bus
    task automatic rd(input logic [15:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(q, exp);
    endtask : rd
    // Strap moves only while reset is held
    task automatic do_reset(input logic s);
        reset_n <= 1'b0;
        strap <= s;
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
    endtask : do_reset
    // Cycles between two ticks, skipping the first tick after a change
    task automatic tick_gap(ref logic t, output int n);
        n = 0;
        repeat (2) do @(posedge clk); while (t !== 1'b1);
        do begin @(posedge clk); n++; end while (t !== 1'b1);
    endtask : tick_gap
    initial begin
        void'($urandom(77178));
        do_reset(1'b0);
        chk(pin_oe, 1'b1);
        rd(`CSC_ADDR_SLEW, `CSC_SLEW_RST);
        rd(`CSC_ADDR_STATUS3, 32'h0);
        bus(1'b1, 16'h7070, $urandom);
        rd(16'h7070, 32'h0);
        k = $urandom;
        bus(1'b1, `CSC_ADDR_SLEW, k);
        rd(`CSC_ADDR_SLEW, k & 32'hffff);
        chk(slew, k[15:0]);
        for (r = 0; r < 4; r++) begin
            bus(1'b1, `CSC_ADDR_SRCSEL, ($urandom & 32'hfffffffc) | r);
            rd(`CSC_ADDR_SRCSEL, r);
            // With the strap low and bypass set, sources 0 to 2 all carry the oscillator
            if (r < 3) begin
                chk(pin_o, rtc_d2);
            end
            chk(rtcc, rtc_d1);
            chk(sysr, rtc_d1);
        end
        bus(1'b1, `CSC_ADDR_STATUS3, 32'h1);
        repeat (4) @(posedge clk);
        chk(pin_oe, 1'b0);
        rd(`CSC_ADDR_STATUS3, 32'h9);
        bus(1'b1, `CSC_ADDR_STATUS3, 32'h0);
        repeat (3) @(posedge clk);
        chk(pin_oe, 1'b1);
        for (r = 0; r < 4; r++) begin
            k = (r == 3) ? 0 : r;
            bus(1'b1, `CSC_ADDR_BOOTCFG, 32'h10 | r);
            chk(byp, 1'b1);
            tick_gap(spi_t, g);
            chk(g, (refk[k] + 499) / 500);
            tick_gap(i2c_t, g);
            chk(g, (refk[k] + 399) / 400);
        end
        bus(1'b1, `CSC_ADDR_BOOTCFG, 32'h1);
        chk(byp, 1'b0);
        bus(1'b1, `CSC_ADDR_PLLCFG, 32'ha);
        rd(`CSC_ADDR_PLLCFG, 32'ha);
        bus(1'b1, `CSC_ADDR_PLLCFG, 32'hb);
        rd(`CSC_ADDR_PLLCFG, 32'h10a);
        do_reset(1'b1);
        rd(`CSC_ADDR_STATUS3, 32'h4);
        chk(sysr, ext_d1);
        chk(rtcc, rtc_d1);
        repeat (60) @(posedge clk);
        finish_test();
    end
endmodule : tb
